// ===== core/urf_top.sv
// uart rate, frame format and buffer clear logic
// assumes classic wishbone slave, synchronous serial input
// Notes on behaviour
// - bit rate is divisor output frequency divided by sixteen
// - bit order applies only to 8-bit characters, else lsb first
// - order zero sends start, d0..d7, parity, stop
// - order one sends start, d7..d0, parity, stop both ways
// - invert set flips transmit data on buffer write
// - invert set flips received data on buffer read
// - invert clear passes data unchanged
// - edge select zero changes output on falling transfer clock edge
// - stop select zero one stop; parity switch adds parity bit
// - output idles high from mode select, open drain releases instead
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module urf_top (
    input  wire  logic        clk_i,
    input  wire  logic        rst_i,
    input  wire  logic        cyc_i,
    input  wire  logic        stb_i,
    input  wire  logic        we_i,
    input  wire  logic [4:0]  adr_i,
    input  wire  logic [3:0]  sel_i,
    input  wire  logic [31:0] dat_i,
    output var   logic [31:0] dat_o,
    output var   logic        ack_o,
    input  wire  logic        serial_in_pin_i,
    output var   logic        serial_out_pin_o,
    output var   logic        serial_out_pin_oe_o,
    output var   logic        transfer_clock_pin_o
);

    // ****************************************
    // registers
    // ****************************************
    urf_pkg::urf_cfg_t    cfg, next_cfg;
    logic [7:0]           baud_divisor, next_baud_divisor;
    logic [8:0]           transmit_buffer, next_transmit_buffer;
    logic [8:0]           receive_buffer, next_receive_buffer;
    logic                 tx_empty, next_tx_empty;
    logic                 rx_full, next_rx_full;
    logic [31:0]          next_dat;
    logic                 next_ack;
    logic [2:0]           pre, next_pre;
    logic [7:0]           bcnt, next_bcnt;
    logic                 tick;
    logic                 async_on;
    logic [3:0]           dlen;

    function automatic logic [3:0] char_len(input logic [2:0] smd);
        case (smd)
            urf_pkg::SMD_ASYNC7: char_len = 4'd7;
            urf_pkg::SMD_ASYNC9: char_len = 4'd9;
            default:             char_len = 4'd8;
        endcase
    endfunction : char_len

    // bit n of data in wire order for the active length and order
    function automatic logic [8:0] reorder(input logic [8:0] d, input logic msb, input logic [3:0] len);
        logic [8:0] r;
        r = d;
        if (msb && len == 4'd8) begin
            for (int k = 0; k < 8; k++) begin
                r[k] = d[7-k];
            end
        end
        reorder = r;
    endfunction : reorder

    assign async_on = (cfg.smd == urf_pkg::SMD_ASYNC7) || (cfg.smd == urf_pkg::SMD_ASYNC8)
                      || (cfg.smd == urf_pkg::SMD_ASYNC9);
    assign dlen = char_len(cfg.smd);

    // ****************************************
    // baud generator
    // ****************************************
    always_comb begin
        next_pre  = pre + 3'd1;
        next_bcnt = bcnt;
        tick      = 1'b0;
        // source select, divide by n plus one
        if (!cfg.src8 || pre == 3'(urf_pkg::PRESCALE8 - 1)) begin
            if (bcnt == 8'h00) begin
                next_bcnt = baud_divisor;
                tick      = 1'b1;
            end else begin
                next_bcnt = bcnt - 8'd1;
            end
        end
        if (!async_on) begin
            next_pre  = 3'd0;
            next_bcnt = baud_divisor;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre  <= 3'd0;
            bcnt <= 8'h00;
        end else begin
            pre  <= next_pre;
            bcnt <= next_bcnt;
        end
    end

    // ****************************************
    // transmitter
    // ****************************************
    urf_pkg::urf_state_t tst, next_tst;
    logic [3:0]           tph, next_tph;
    logic [3:0]           tidx, next_tidx;
    logic [8:0]           tsh, next_tsh;
    logic                 tpar, next_tpar;
    logic                 tout, next_tout;
    logic                 tload;

    always_comb begin
        next_tst  = tst;
        next_tph  = tph;
        next_tidx = tidx;
        next_tsh  = tsh;
        next_tpar = tpar;
        next_tout = tout;
        tload     = 1'b0;
        if (tick) begin
            next_tph = tph + 4'd1;
        end
        case (tst)
            urf_pkg::URF_IDLE: begin
                next_tout = 1'b1;
                next_tph  = 4'd0;
                if (cfg.tx_allow && !tx_empty && tick) begin
                    tload     = 1'b1;
                    next_tsh  = reorder(transmit_buffer, cfg.msb_first, dlen);
                    next_tpar = cfg.par_odd;
                    next_tidx = 4'd0;
                    next_tout = 1'b0;
                    next_tst  = urf_pkg::URF_START;
                end
            end
            urf_pkg::URF_START: begin
                if (tick && tph == 4'(urf_pkg::OVERSAMPLE - 1)) begin
                    next_tout = tsh[0];
                    next_tst  = urf_pkg::URF_DATA;
                end
            end
            urf_pkg::URF_DATA: begin
                if (tick && tph == 4'(urf_pkg::OVERSAMPLE - 1)) begin
                    next_tpar = tpar ^ tsh[0];
                    next_tsh  = {1'b0, tsh[8:1]};
                    next_tidx = tidx + 4'd1;
                    if (tidx + 4'd1 == dlen) begin
                        next_tout = cfg.par_en ? (tpar ^ tsh[0]) : 1'b1;
                        next_tidx = cfg.par_en ? 4'd0 : 4'd1;
                        next_tst  = urf_pkg::URF_TAIL;
                    end else begin
                        next_tout = tsh[1];
                    end
                end
            end
            urf_pkg::URF_TAIL: begin
                if (tick && tph == 4'(urf_pkg::OVERSAMPLE - 1)) begin
                    next_tout = 1'b1;
                    next_tidx = tidx + 4'd1;
                    if (tidx == (cfg.two_stop ? 4'd2 : 4'd1)) begin
                        next_tst = urf_pkg::URF_IDLE;
                    end
                end
            end
            default: next_tst = urf_pkg::URF_IDLE;
        endcase
        if (!async_on) begin
            next_tst  = urf_pkg::URF_IDLE;
            next_tout = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tst  <= urf_pkg::URF_IDLE;
            tph  <= 4'd0;
            tidx <= 4'd0;
            tsh  <= 9'h000;
            tpar <= 1'b0;
            tout <= 1'b1;
        end else begin
            tst  <= next_tst;
            tph  <= next_tph;
            tidx <= next_tidx;
            tsh  <= next_tsh;
            tpar <= next_tpar;
            tout <= next_tout;
        end
    end

    // ****************************************
    // receiver
    // ****************************************
    urf_pkg::urf_state_t rst_q, next_rst_q;
    logic [3:0]           rph, next_rph;
    logic [3:0]           ridx, next_ridx;
    logic [8:0]           rsh, next_rsh;
    logic                 rdone;

    always_comb begin
        next_rst_q = rst_q;
        next_rph   = rph;
        next_ridx  = ridx;
        next_rsh   = rsh;
        rdone      = 1'b0;
        if (tick) begin
            next_rph = rph + 4'd1;
        end
        case (rst_q)
            urf_pkg::URF_IDLE: begin
                next_rph = 4'd0;
                if (tick && !serial_in_pin_i) begin
                    next_ridx  = 4'd0;
                    next_rst_q = urf_pkg::URF_START;
                end
            end
            urf_pkg::URF_START: begin
                if (tick && rph == 4'(urf_pkg::OVERSAMPLE / 2 - 1)) begin
                    next_rph   = 4'd0;
                    next_rst_q = serial_in_pin_i ? urf_pkg::URF_IDLE : urf_pkg::URF_DATA;
                end
            end
            urf_pkg::URF_DATA: begin
                if (tick && rph == 4'(urf_pkg::OVERSAMPLE - 1)) begin
                    next_rsh  = rsh;
                    next_rsh[ridx] = serial_in_pin_i;
                    next_ridx = ridx + 4'd1;
                    if (ridx + 4'd1 == dlen) begin
                        next_ridx  = cfg.par_en ? 4'd0 : 4'd1;
                        next_rst_q = urf_pkg::URF_TAIL;
                    end
                end
            end
            urf_pkg::URF_TAIL: begin
                if (tick && rph == 4'(urf_pkg::OVERSAMPLE - 1)) begin
                    next_ridx = ridx + 4'd1;
                    if (ridx == 4'd1) begin
                        rdone      = 1'b1;
                        next_rst_q = urf_pkg::URF_IDLE;
                    end
                end
            end
            default: next_rst_q = urf_pkg::URF_IDLE;
        endcase
        if (!async_on || !cfg.rx_allow) begin
            next_rst_q = urf_pkg::URF_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_q <= urf_pkg::URF_IDLE;
            rph   <= 4'd0;
            ridx  <= 4'd0;
            rsh   <= 9'h000;
        end else begin
            rst_q <= next_rst_q;
            rph   <= next_rph;
            ridx  <= next_ridx;
            rsh   <= next_rsh;
        end
    end

    // ****************************************
    // wishbone registers
    // ****************************************
    always_comb begin
        logic wr;
        logic [8:0] rd;
        wr                   = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
        rd                   = receive_buffer;
        next_cfg             = cfg;
        next_baud_divisor    = baud_divisor;
        next_transmit_buffer = transmit_buffer;
        next_receive_buffer  = receive_buffer;
        next_tx_empty        = tx_empty;
        next_rx_full         = rx_full;
        next_ack             = cyc_i && stb_i && !ack_o;
        next_dat             = 32'h0000_0000;
        if (tload) begin
            next_tx_empty = 1'b1;
        end
        if (rdone) begin
            next_receive_buffer = reorder(rsh, cfg.msb_first, dlen);
            next_rx_full        = 1'b1;
        end
        if (wr) begin
            case (adr_i)
                5'(urf_pkg::ADDR_MODE): begin
                    next_cfg.smd      = dat_i[urf_pkg::MODE_SMD_LSB +: 3];
                    next_cfg.two_stop = dat_i[urf_pkg::MODE_STOP_LENGTH_SELECT_BIT];
                    next_cfg.par_en   = dat_i[urf_pkg::MODE_PAR_BIT];
                    next_cfg.par_odd  = dat_i[urf_pkg::MODE_ODD_BIT];
                end
                5'(urf_pkg::ADDR_CTRL0): begin
                    next_cfg.src8       = dat_i[urf_pkg::C0_SRC_BIT];
                    next_cfg.open_drain = dat_i[urf_pkg::C0_OD_BIT];
                    next_cfg.edge_sel   = dat_i[urf_pkg::C0_EDGE_BIT];
                    next_cfg.msb_first  = dat_i[urf_pkg::C0_ORDER_BIT];
                end
                5'(urf_pkg::ADDR_CTRL1): begin
                    next_cfg.tx_allow = dat_i[urf_pkg::C1_TXA_BIT];
                    next_cfg.rx_allow = dat_i[urf_pkg::C1_RXA_BIT];
                    next_cfg.inv      = dat_i[urf_pkg::C1_INV_BIT];
                end
                5'(urf_pkg::ADDR_DIVISOR): next_baud_divisor = dat_i[7:0];
                urf_pkg::ADDR_TXBUF: begin
                    next_transmit_buffer = cfg.inv ? ~dat_i[8:0] : dat_i[8:0];
                    next_tx_empty        = 1'b0;
                end
                default: ;
            endcase
        end
        if (!cfg.rx_allow && !rdone) begin
            next_rx_full = 1'b0;
        end
        if (!async_on) begin
            next_tx_empty = 1'b1;
        end
        if (cyc_i && stb_i && !we_i && !ack_o) begin
            case (adr_i)
                5'(urf_pkg::ADDR_MODE): next_dat = {25'h0, cfg.par_odd, cfg.par_en, cfg.two_stop, 1'b0, cfg.smd};
                5'(urf_pkg::ADDR_CTRL0): next_dat = {27'h0, (tst == urf_pkg::URF_IDLE), cfg.msb_first,
                                                     cfg.edge_sel, cfg.open_drain, cfg.src8};
                5'(urf_pkg::ADDR_CTRL1): next_dat = {27'h0, cfg.inv, rx_full, cfg.rx_allow, tx_empty, cfg.tx_allow};
                5'(urf_pkg::ADDR_DIVISOR): next_dat = {24'h0, baud_divisor};
                urf_pkg::ADDR_TXBUF: next_dat = {23'h0, transmit_buffer};
                urf_pkg::ADDR_RXBUF: begin
                    next_dat     = {23'h0, cfg.inv ? ~rd : rd};
                    if (!rdone) begin
                        next_rx_full = 1'b0;
                    end
                end
                default: next_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg             <= '0;
            baud_divisor    <= urf_pkg::DIV_RESET;
            transmit_buffer <= 9'h000;
            receive_buffer  <= 9'h000;
            tx_empty        <= 1'b1;
            rx_full         <= 1'b0;
            ack_o           <= 1'b0;
            dat_o           <= 32'h0000_0000;
        end else begin
            cfg             <= next_cfg;
            baud_divisor    <= next_baud_divisor;
            transmit_buffer <= next_transmit_buffer;
            receive_buffer  <= next_receive_buffer;
            tx_empty        <= next_tx_empty;
            rx_full         <= next_rx_full;
            ack_o           <= next_ack;
            dat_o           <= next_dat;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_out_pin_o     <= 1'b1;
            serial_out_pin_oe_o  <= 1'b1;
            transfer_clock_pin_o <= 1'b1;
        end else begin
            serial_out_pin_o     <= tout;
            serial_out_pin_oe_o  <= !(async_on && !(cfg.open_drain && tout));
            // bit changes align with falling transfer clock when edge_sel is zero, rising when set
            transfer_clock_pin_o <= cfg.edge_sel ^ ((tst == urf_pkg::URF_IDLE)
                                    || (tph >= 4'(urf_pkg::OVERSAMPLE / 2)));
        end
    end

endmodule : urf_top
`default_nettype wire

// ===== core/urf_pkg.sv
// package for the uart rate and format block
// assumes a classic wishbone slave with 32-bit data
package urf_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [3:0] ADDR_MODE    = 4'h0;
    localparam logic [3:0] ADDR_CTRL0   = 4'h4;
    localparam logic [3:0] ADDR_CTRL1   = 4'h8;
    localparam logic [3:0] ADDR_DIVISOR = 4'hC;
    localparam logic [4:0] ADDR_TXBUF   = 5'h10;
    localparam logic [4:0] ADDR_RXBUF   = 5'h14;

    // ****************************************
    // field positions
    // ****************************************
    localparam int MODE_SMD_LSB   = 0;
    localparam int MODE_STOP_LENGTH_SELECT_BIT  = 4;
    localparam int MODE_PAR_BIT   = 5;
    localparam int MODE_ODD_BIT   = 6;
    localparam int C0_SRC_BIT     = 0;
    localparam int C0_OD_BIT      = 1;
    localparam int C0_EDGE_BIT    = 2;
    localparam int C0_ORDER_BIT   = 3;
    localparam int C0_BUSY_BIT    = 4;
    localparam int C1_TXA_BIT     = 0;
    localparam int C1_TXE_BIT     = 1;
    localparam int C1_RXA_BIT     = 2;
    localparam int C1_RXF_BIT     = 3;
    localparam int C1_INV_BIT     = 4;

    // ****************************************
    // mode codes and constants
    // ****************************************
    localparam logic [2:0] SMD_OFF    = 3'h0;
    localparam logic [2:0] SMD_ASYNC7 = 3'h4;
    localparam logic [2:0] SMD_ASYNC8 = 3'h5;
    localparam logic [2:0] SMD_ASYNC9 = 3'h6;
    localparam int          OVERSAMPLE = 16;
    localparam int          PRESCALE8  = 8;
    localparam logic [7:0]  DIV_RESET  = 8'h00;

    typedef enum logic [1:0] {
        URF_IDLE,
        URF_START,
        URF_DATA,
        URF_TAIL
    } urf_state_t;

    typedef struct packed {
        logic [2:0] smd;
        logic       two_stop;
        logic       par_en;
        logic       par_odd;
        logic       src8;
        logic       open_drain;
        logic       edge_sel;
        logic       msb_first;
        logic       tx_allow;
        logic       rx_allow;
        logic       inv;
    } urf_cfg_t;

endpackage : urf_pkg

// ===== testbench/urf_top_sva.sv
// port checker for urf_top
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module urf_top_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic serial_out_pin_o,
    input wire logic serial_out_pin_oe_o,
    input wire logic transfer_clock_pin_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************************************
    // sequences
    // ****************************************
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence clk_hi_s;
        transfer_clock_pin_o [*8];
    endsequence
    sequence clk_lo_s;
        !transfer_clock_pin_o [*8];
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    ack_timing_a: assert property (req_s |=> ack_o)
        else $error("ack missing one cycle after request");
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
        else $error("ack without request");
    idle_high_a: assert property ($fell(rst_i) |-> serial_out_pin_o && serial_out_pin_oe_o)
        else $error("line not idle after reset");
    out_edge_a: assert property ($changed(serial_out_pin_o) && !serial_out_pin_oe_o
        && $stable(serial_out_pin_oe_o) |-> $fell(transfer_clock_pin_o))
        else $error("data changed off falling transfer clock");
    rise_steady_a: assert property ($rose(transfer_clock_pin_o) |-> $stable(serial_out_pin_o))
        else $error("data changed on rising transfer clock");
    clk_high_a: assert property ($rose(transfer_clock_pin_o) |-> clk_hi_s)
        else $error("transfer clock high phase too short");
    clk_low_a: assert property ($fell(transfer_clock_pin_o) |-> clk_lo_s)
        else $error("transfer clock low phase too short");
endmodule : urf_top_sva
bind urf_top urf_top_sva i_urf_top_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe_o(serial_out_pin_oe_o),
    .transfer_clock_pin_o(transfer_clock_pin_o));
`default_nettype wire

// ===== testbench/urf_peer.sv
// remote serial peer on the line of urf_top
// assumes an idle-high line and a bit time given in clk cycles
`timescale 1ns/1ps
`default_nettype none
module urf_peer (
    input  wire logic        clk_i,
    input  wire logic        line_i,
    input  wire logic [15:0] bit_cyc_i,
    input  wire logic [3:0]  nbits_i,
    output var  logic        serial_o,
    output var  logic [11:0] frame_o,
    output var  logic        got_o
);
    // ****************************************
    // receiver: mid-bit sampling after start
    // ****************************************
    initial begin
        serial_o = 1'b1;
        frame_o  = 12'h000;
        got_o    = 1'b0;
        forever begin
            @(negedge line_i);
            frame_o = 12'h000;
            repeat (bit_cyc_i / 2) @(posedge clk_i);
            for (int i = 0; i < 32'(nbits_i); i++) begin
                repeat (bit_cyc_i) @(posedge clk_i);
                frame_o[i] = line_i;
            end
            got_o = 1'b1;
            @(posedge clk_i);
            got_o = 1'b0;
        end
    end
    // ****************************************
    // transmitter: bit 0 first, gap sets pace
    // ****************************************
    task automatic send(input logic [11:0] bits, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            serial_o <= bits[i];
            repeat (bit_cyc_i) @(posedge clk_i);
        end
        serial_o <= 1'b1;
        repeat (gap) @(posedge clk_i);
    endtask : send
endmodule : urf_peer
`default_nettype wire

// ===== testbench/urf_top_test.sv
// self-checking bench for urf_top
// assumes urf_peer as far side and the bound port checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module urf_top_test;
    logic              clk_i   = 1'b0;
    logic              rst_i   = 1'b1;
    logic              cyc_i   = 1'b0;
    logic              stb_i   = 1'b0;
    logic              we_i    = 1'b0;
    logic [4:0]        adr_i   = 5'h00;
    logic [3:0]        sel_i   = 4'h0;
    logic [31:0]       dat_i   = 32'h0000_0000;
    logic [15:0]       bit_cyc = 16'h0020;
    logic [3:0]        nbits   = 4'h9;
    logic [31:0]       dat_o;
    logic              ack_o;
    logic              sin;
    logic              sout;
    logic              soe;
    logic              got;
    logic [11:0]       frame;
    int                err_total = 0;
    int                n_checks  = 0;
    int                fcount    = 0;
    int                seed      = 53934;
    logic [63:0]       rd_q[$];
    logic [11:0]       fr_q[$];
    urf_pkg::urf_cfg_t cfg;
    wire logic         line = soe ? 1'b1 : sout;

    always #12.5 clk_i = ~clk_i;
    urf_top i_urf_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .serial_in_pin_i(sin), .serial_out_pin_o(sout), .serial_out_pin_oe_o(soe),
        .transfer_clock_pin_o());
    urf_peer i_urf_peer (.clk_i(clk_i), .line_i(line), .bit_cyc_i(bit_cyc), .nbits_i(nbits),
        .serial_o(sin), .frame_o(frame), .got_o(got));
    // ****************************************
    // result monitors
    // ****************************************
    always @(posedge clk_i) begin : rd_mon
        logic [63:0] nt;
        if (ack_o && !we_i) begin
            nt = rd_q.pop_front();
            `CHK(dat_o & nt[63:32], nt[31:0])
        end
    end
    always @(posedge got) begin : fr_mon
        `CHK(frame, fr_q.pop_front())
        fcount++;
    end
    // ****************************************
    // bus tasks and helpers
    // ****************************************
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            k++;
        end while (!ack_o && k < 50);
        q = dat_o;
        if (!ack_o) begin
            err_total++;
            final_report();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, output logic [31:0] q);
        rd_q.push_back({m, e});
        wb(1'b0, a, 32'h0000_0000, q);
    endtask : rd
    task automatic put_cfg(input logic [7:0] div);
        wr(5'h00, {25'h0, cfg.par_odd, cfg.par_en, cfg.two_stop, 1'b0, cfg.smd});
        wr(5'h04, {28'h0, cfg.msb_first, cfg.edge_sel, cfg.open_drain, cfg.src8});
        wr(5'h08, {27'h0, cfg.inv, 1'b0, cfg.rx_allow, 1'b0, cfg.tx_allow});
        wr(5'h0C, {24'h0, div});
    endtask : put_cfg
    task automatic wait_frame(input int c0);
        int k;
        k = 0;
        while (fcount == c0 && k < 8000) begin
            @(posedge clk_i);
            k++;
        end
        if (fcount == c0) begin
            err_total++;
            final_report();
        end
        repeat (bit_cyc) @(posedge clk_i);
    endtask : wait_frame
    // wire order of data, parity and stop bits after the start bit
    function automatic logic [11:0] exp_frame(input int len, input logic ord, input logic inv,
                                              input logic par, input logic [8:0] d);
        logic [8:0]  w;
        logic [11:0] f;
        w = inv ? ~d : d;
        f = 12'h000;
        for (int i = 0; i < len; i++) begin
            f[i] = (len == 8 && ord) ? w[7 - i] : w[i];
        end
        if (par) begin
            f[len] = ^(w & ((9'h001 << len) - 9'h001));
        end
        f[len + 32'(par)] = 1'b1;
        return f;
    endfunction : exp_frame
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int          len;
        int          c0;
        logic [8:0]  d;
        logic [11:0] f;
        logic [15:0] cnt;
        logic [31:0] v;
        cfg = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(5'h0C, 32'h0000_00FF, {24'h0, urf_pkg::DIV_RESET}, v);
        wr(5'h18, 32'hFFFF_FFFF);
        rd(5'h18, 32'hFFFF_FFFF, 32'h0000_0000, v);
        cfg.smd = urf_pkg::SMD_ASYNC8;
        put_cfg(8'h01);
        `CHK({sout, soe}, 2'b10)
        cfg.open_drain = 1'b1;
        put_cfg(8'h01);
        `CHK(soe, 1'b1)
        cfg.open_drain = 1'b0;
        cfg.tx_allow = 1'b1;
        for (int j = 0; j < 2; j++) begin
            cfg.src8 = j[0];
            bit_cyc = j ? 16'h0080 : 16'h0030;
            put_cfg(j ? 8'h00 : 8'h02);
            c0 = fcount;
            fr_q.push_back(exp_frame(8, 1'b0, 1'b0, 1'b0, 9'h055));
            wr(urf_pkg::ADDR_TXBUF, 32'h0000_0055);
            cnt = 16'h0000;
            for (int k = 0; k < 4000 && sout; k++) @(posedge clk_i);
            while (!sout && cnt < 16'h1000) begin
                @(posedge clk_i);
                cnt++;
            end
            `CHK(cnt, bit_cyc)
            wait_frame(c0);
        end
        cfg.src8 = 1'b0;
        bit_cyc = 16'h0020;
        for (int m = 0; m < 24; m++) begin
            len = 7 + m % 3;
            cfg.smd = len == 7 ? urf_pkg::SMD_ASYNC7 : len == 8 ? urf_pkg::SMD_ASYNC8 : urf_pkg::SMD_ASYNC9;
            cfg.msb_first = m[0];
            cfg.inv = m[1];
            cfg.par_en = m[2];
            cfg.two_stop = m[3];
            nbits = 4'(len + 1 + m[2] + m[3]);
            d = 9'($random(seed));
            put_cfg(8'h01);
            c0 = fcount;
            fr_q.push_back(exp_frame(len, m[0], m[1], m[2], d) | 12'(m[3]) << (nbits - 4'd1));
            wr(urf_pkg::ADDR_TXBUF, {23'h0, d});
            wait_frame(c0);
        end
        cfg.tx_allow = 1'b0;
        cfg.rx_allow = 1'b1;
        cfg.msb_first = 1'b1;
        cfg.par_en = 1'b1;
        for (int j = 0; j < 4; j++) begin
            len = j < 2 ? 8 : 7;
            cfg.smd = j < 2 ? urf_pkg::SMD_ASYNC8 : urf_pkg::SMD_ASYNC7;
            cfg.inv = j[0];
            put_cfg(8'h01);
            d = 9'($random(seed)) & 9'((32'h1 << len) - 1);
            f = exp_frame(len, 1'b1, j[0], 1'b1, d);
            i_urf_peer.send({f[10:0], 1'b0}, len + 3, j * 40);
            v = 32'h0000_0000;
            for (int k = 0; k < 20 && !v[urf_pkg::C1_RXF_BIT]; k++) rd(5'h08, 32'h0, 32'h0, v);
            if (j == 3) begin
                wr(5'h08, 32'h0000_0010);
                wr(5'h08, 32'h0000_0014);
                rd(5'h08, 32'h0000_0008, 32'h0000_0000, v);
            end else begin
                rd(urf_pkg::ADDR_RXBUF, (32'h1 << len) - 1, {23'h0, d}, v);
            end
        end
        cfg.smd = urf_pkg::SMD_ASYNC8;
        cfg.rx_allow = 1'b0;
        put_cfg(8'h01);
        wr(urf_pkg::ADDR_TXBUF, 32'h0000_00A5);
        rd(5'h08, 32'h0000_0002, 32'h0000_0000, v);
        wr(5'h00, {29'h0, urf_pkg::SMD_OFF});
        wr(5'h00, {29'h0, urf_pkg::SMD_ASYNC8});
        wr(5'h08, 32'h0000_0004);
        rd(5'h08, 32'h0000_0006, 32'h0000_0006, v);
        repeat (4) @(posedge clk_i);
        final_report();
    end
endmodule : urf_top_test
`default_nettype wire
